//--- pem_cfg.svh
`ifndef PEM_CFG_SVH
`define PEM_CFG_SVH

// register offsets, low twelve bits; the top nibble carries the channel number
`define PEM_OFS_CTRL_LOW       12'h183
`define PEM_OFS_IRQ_STAT_HIGH  12'h18A
`define PEM_OFS_IRQ_STAT_LOW   12'h18B
`define PEM_OFS_PAR_TALLY_B3   12'h198
`define PEM_OFS_PAR_TALLY_B2   12'h199
`define PEM_OFS_PAR_TALLY_B1   12'h19A
`define PEM_OFS_PAR_TALLY_B0   12'h19B
`define PEM_OFS_REM_TALLY_B3   12'h19C
`define PEM_OFS_REM_TALLY_B2   12'h19D
`define PEM_OFS_REM_TALLY_B1   12'h19E
`define PEM_OFS_REM_TALLY_B0   12'h19F

// control byte fields
`define PEM_CTRL_PAR_MODE_BIT  0
`define PEM_CTRL_REM_MODE_BIT  1
`define PEM_CTRL_RW_MASK       8'h0F
`define PEM_CTRL_RESET         8'h01

// interrupt status fields
`define PEM_STAT_PARITY_BIT    7
`define PEM_STAT_REMOTE_BIT    6

// remote error nibble: values above this carry no errors
`define PEM_REM_MAX            4'h8

`endif

//--- pem_pkg.sv
package pem_pkg;

    // one byte of the incoming spe stream with its markers
    typedef struct packed {
        logic       valid;  // byte present this cycle
        logic       first;  // first byte of a new spe
        logic       is_b3;  // this byte is the path parity byte
        logic       is_g1;  // this byte is the path status byte
        logic [7:0] data;   // byte value
    } pem_spe_type;

    // remote error report to the paired transmit path
    typedef struct packed {
        logic       valid;  // one-cycle strobe per checked spe
        logic [3:0] count;  // nibble to send back
    } pem_rei_type;

    // state of the parity reference
    typedef enum logic [1:0] {
        PEM_REF_NONE = 2'b00,  // no complete spe seen yet
        PEM_REF_HELD = 2'b01,  // previous spe parity held, b3 awaited
        PEM_REF_USED = 2'b10   // b3 checked for this spe
    } pem_ref_type;

endpackage

//--- pem_path_error_monitor.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "pem_cfg.svh"
// Overview of operation
// RULE1 - remote mode 1: add one per nonzero spe
// RULE2 - remote mode 0: add nibble value, max 8
// RULE3 - parity mode 1: add one per errored spe
// RULE4 - bip-8 over spe, checked against next b3
// RULE5 - parity error sets status bit 7, irq low
// RULE6 - per-spe mode: returned nibble at most 1
// RULE7 - parity mode 0: add mismatching bit count
// RULE8 - parity tally is 32-bit, mode dependent
// RULE9 - nonzero remote nibble sets bit 6, irq low
// RULE10 - read-clear bytes return value then clear
module pem_path_error_monitor #(
    parameter int CHANNEL_ID = 1  // per-channel address nibble
) (
    input  wire logic                 sys_clk_i,     // 25 MHz system clock
    input  wire logic                 rst_i,         // synchronous, active high
    input  wire logic                 ce_i,          // clock enable, freezes state when low
    input  wire pem_pkg::pem_spe_type spe_i,         // spe stream from overhead processor
    input  wire logic [15:0]          reg_addr_i,    // register address
    input  wire logic [7:0]           reg_wdata_i,   // register write data
    input  wire logic                 reg_wr_i,      // write strobe
    input  wire logic                 reg_rd_i,      // read strobe
    output      logic [7:0]           reg_rdata_o,   // read data, cycle after strobe
    output      pem_pkg::pem_rei_type rei_o,         // nibble for transmit path
    output      logic                 irq_n_o        // interrupt, active low
);

    // the address nibble must fit in four bits
    generate
        if (CHANNEL_ID < 0 || CHANNEL_ID > 15) begin : g_bad_chan
            $error("CHANNEL_ID must be 0 to 15");
        end
    endgenerate

    localparam logic [3:0] CHAN = 4'(CHANNEL_ID);  // address nibble

    // number of ones in a byte, used for parity bit errors
    function automatic logic [3:0] pop8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'b000, v[i]};
        end
        return n;
    endfunction

    // byte clear mask for one of four tally bytes
    function automatic logic [31:0] byte_mask(input logic [1:0] sel);
        return 32'h0000_00FF << {sel, 3'b000};
    endfunction

    // state
    logic [7:0]           ctrl_r;          // control byte
    logic [7:0]           bip_acc_r;       // running parity of current spe
    logic [7:0]           bip_ref_r;       // parity of previous spe
    pem_pkg::pem_ref_type ref_st_r;        // reference state
    logic [31:0]          par_tally_r;     // parity error tally
    logic [31:0]          rem_tally_r;     // remote error tally
    logic                 stat_par_r;      // parity error status
    logic                 stat_rem_r;      // remote error status
    logic [7:0]           rdata_r;         // registered read data
    pem_pkg::pem_rei_type rei_r;           // registered report

    // decoded access
    logic                 hit;             // address is this channel
    logic [11:0]          ofs;             // low twelve address bits
    logic                 rd_hit;          // read of this channel
    logic                 wr_hit;          // write of this channel

    // event terms
    logic                 b3_check;        // b3 byte compared this cycle
    logic [7:0]           bip_diff;        // mismatching parity bits
    logic [3:0]           par_bits;        // number of mismatching bits
    logic                 par_err;         // at least one mismatch
    logic                 g1_seen;         // status byte this cycle
    logic [3:0]           rem_nib;         // received remote nibble, cleaned
    logic                 rem_err;         // nonzero remote nibble
    logic [31:0]          par_inc;         // parity tally increment
    logic [31:0]          rem_inc;         // remote tally increment
    logic [31:0]          par_clr;         // bytes cleared by read
    logic [31:0]          rem_clr;         // bytes cleared by read

    // address decode: top nibble selects the channel
    assign hit    = (reg_addr_i[15:12] == CHAN);
    assign ofs    = reg_addr_i[11:0];
    assign rd_hit = reg_rd_i & hit;
    assign wr_hit = reg_wr_i & hit;

    // parity compare; only valid once a whole spe has been seen
    assign b3_check = spe_i.valid & spe_i.is_b3 & (ref_st_r == pem_pkg::PEM_REF_HELD);
    assign bip_diff = bip_ref_r ^ spe_i.data;                           // [RULE4]
    assign par_bits = pop8(bip_diff);
    assign par_err  = b3_check & (bip_diff != 8'h00);

    // remote nibble sits in the upper half of the status byte;
    // codes above eight carry no error count, so they are dropped
    assign g1_seen = spe_i.valid & spe_i.is_g1;
    assign rem_nib = (g1_seen && spe_i.data[7:4] <= `PEM_REM_MAX) ? spe_i.data[7:4] : 4'h0;
    assign rem_err = (rem_nib != 4'h0);

    // tally increments by mode
    always_comb begin
        par_inc = 32'h0;
        rem_inc = 32'h0;
        if (par_err) begin
            if (ctrl_r[`PEM_CTRL_PAR_MODE_BIT]) begin
                par_inc = 32'h1;                                        // [RULE3]
            end else begin
                par_inc = {28'h0, par_bits};                            // [RULE7]
            end
        end
        if (rem_err) begin
            if (ctrl_r[`PEM_CTRL_REM_MODE_BIT]) begin
                rem_inc = 32'h1;                                        // [RULE1]
            end else begin
                rem_inc = {28'h0, rem_nib};                             // [RULE2]
            end
        end
    end

    // which tally bytes a read clears
    always_comb begin
        par_clr = 32'h0;
        rem_clr = 32'h0;
        if (rd_hit) begin
            case (ofs)
                `PEM_OFS_PAR_TALLY_B3: par_clr = byte_mask(2'd3);
                `PEM_OFS_PAR_TALLY_B2: par_clr = byte_mask(2'd2);
                `PEM_OFS_PAR_TALLY_B1: par_clr = byte_mask(2'd1);
                `PEM_OFS_PAR_TALLY_B0: par_clr = byte_mask(2'd0);
                `PEM_OFS_REM_TALLY_B3: rem_clr = byte_mask(2'd3);
                `PEM_OFS_REM_TALLY_B2: rem_clr = byte_mask(2'd2);
                `PEM_OFS_REM_TALLY_B1: rem_clr = byte_mask(2'd1);
                `PEM_OFS_REM_TALLY_B0: rem_clr = byte_mask(2'd0);
                default: begin
                    par_clr = 32'h0;
                    rem_clr = 32'h0;
                end
            endcase
        end
    end

    // control byte; only the four low bits are writable
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_r <= `PEM_CTRL_RESET;
        end else if (ce_i && wr_hit && ofs == `PEM_OFS_CTRL_LOW) begin
            ctrl_r <= reg_wdata_i & `PEM_CTRL_RW_MASK;
        end
    end

    // running parity: restart on the first byte of each spe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bip_acc_r <= 8'h00;
            bip_ref_r <= 8'h00;
        end else if (ce_i && spe_i.valid) begin
            if (spe_i.first) begin
                bip_ref_r <= bip_acc_r;                                 // [RULE4]
                bip_acc_r <= spe_i.data;
            end else begin
                bip_acc_r <= bip_acc_r ^ spe_i.data;                    // [RULE4]
            end
        end
    end

    // reference state: the first spe after reset has nothing to check
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_st_r <= pem_pkg::PEM_REF_NONE;
        end else if (ce_i && spe_i.valid) begin
            case (ref_st_r)
                pem_pkg::PEM_REF_NONE: begin
                    if (spe_i.first) begin
                        ref_st_r <= pem_pkg::PEM_REF_USED;
                    end
                end
                pem_pkg::PEM_REF_HELD: begin
                    if (spe_i.first) begin
                        ref_st_r <= pem_pkg::PEM_REF_HELD;
                    end else if (spe_i.is_b3) begin
                        ref_st_r <= pem_pkg::PEM_REF_USED;
                    end
                end
                pem_pkg::PEM_REF_USED: begin
                    if (spe_i.first) begin
                        ref_st_r <= pem_pkg::PEM_REF_HELD;
                    end
                end
                default: ref_st_r <= pem_pkg::PEM_REF_NONE;
            endcase
        end
    end

    // the very first spe only opens the reference; it becomes held at
    // the next spe start, so a b3 in the first spe is never judged

    // tallies: read clears its byte, a same-cycle increment still lands
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            par_tally_r <= 32'h0;
        end else if (ce_i) begin
            par_tally_r <= (par_tally_r & ~par_clr) + par_inc;          // [RULE8] [RULE10]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rem_tally_r <= 32'h0;
        end else if (ce_i) begin
            rem_tally_r <= (rem_tally_r & ~rem_clr) + rem_inc;          // [RULE10]
        end
    end

    // sticky status; set wins over the read that clears it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stat_par_r <= 1'b0;
        end else if (ce_i) begin
            stat_par_r <= par_err |                                      // [RULE5]
                (stat_par_r & ~(rd_hit && ofs == `PEM_OFS_IRQ_STAT_LOW)); // [RULE10]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stat_rem_r <= 1'b0;
        end else if (ce_i) begin
            stat_rem_r <= rem_err |                                      // [RULE9]
                (stat_rem_r & ~(rd_hit && ofs == `PEM_OFS_IRQ_STAT_HIGH)); // [RULE10]
        end
    end

    // report to the transmit path once per checked b3
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rei_r <= '0;
        end else if (ce_i) begin
            rei_r.valid <= b3_check;
            if (b3_check) begin
                if (ctrl_r[`PEM_CTRL_PAR_MODE_BIT]) begin
                    rei_r.count <= {3'b000, par_err};                   // [RULE6]
                end else begin
                    rei_r.count <= par_bits;
                end
            end
        end
    end

    // read data: old value captured, clear happens in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (ce_i) begin
            rdata_r <= 8'h00;
            if (rd_hit) begin
                case (ofs)
                    `PEM_OFS_CTRL_LOW:      rdata_r <= ctrl_r;
                    `PEM_OFS_IRQ_STAT_LOW:  rdata_r <= {stat_par_r, 7'h00};
                    `PEM_OFS_IRQ_STAT_HIGH: rdata_r <= {1'b0, stat_rem_r, 6'h00};
                    `PEM_OFS_PAR_TALLY_B3:  rdata_r <= par_tally_r[31:24];
                    `PEM_OFS_PAR_TALLY_B2:  rdata_r <= par_tally_r[23:16];
                    `PEM_OFS_PAR_TALLY_B1:  rdata_r <= par_tally_r[15:8];
                    `PEM_OFS_PAR_TALLY_B0:  rdata_r <= par_tally_r[7:0];
                    `PEM_OFS_REM_TALLY_B3:  rdata_r <= rem_tally_r[31:24];
                    `PEM_OFS_REM_TALLY_B2:  rdata_r <= rem_tally_r[23:16];
                    `PEM_OFS_REM_TALLY_B1:  rdata_r <= rem_tally_r[15:8];
                    `PEM_OFS_REM_TALLY_B0:  rdata_r <= rem_tally_r[7:0];
                    default:                rdata_r <= 8'h00;  // unmapped reads zero
                endcase
            end
        end
    end

    // outputs
    assign reg_rdata_o = rdata_r;
    assign rei_o       = rei_r;
    assign irq_n_o     = ~(stat_par_r | stat_rem_r);                    // [RULE5] [RULE9]

endmodule

//--- pem_asserts.sv
`timescale 1ns/1ps
module pem_asserts #(
    parameter int CHANNEL_ID = 1  // must match the monitor's channel nibble
) (
    input wire logic                 sys_clk_i,
    input wire logic                 rst_i,
    input wire logic                 ce_i,
    input wire pem_pkg::pem_spe_type spe_i,
    input wire logic [15:0]          reg_addr_i,
    input wire logic [7:0]           reg_wdata_i,
    input wire logic                 reg_wr_i,
    input wire logic                 reg_rd_i,
    input wire logic [7:0]           reg_rdata_o,
    input wire pem_pkg::pem_rei_type rei_o,
    input wire logic                 irq_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    localparam logic [15:0] BASE = 16'(CHANNEL_ID * 4096);  // channel nibble on top
    logic      per_spe_r;  // mirror of the parity tally mode bit
    wire logic g1_ev  = spe_i.valid && spe_i.is_g1;  // status byte taken
    wire logic rd_rem = reg_rd_i && reg_addr_i == (BASE | 16'h019F);  // low remote byte
    // mirror only what software writes; reset value is per-spe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            per_spe_r <= 1'b1;
        end else if (ce_i && reg_wr_i && reg_addr_i == (BASE | 16'h0183)) begin
            per_spe_r <= reg_wdata_i[0];
        end
    end
    property p_rei_cause; rei_o.valid |-> $past(spe_i.valid && spe_i.is_b3); endproperty
    a_rei_cause: assert property (p_rei_cause) else $error("nibble without parity byte");
    property p_rei_max; rei_o.valid |-> rei_o.count <= 4'h8; endproperty
    a_rei_max: assert property (p_rei_max) else $error("bit error count above 8");
    // mode sampled with the parity byte, one cycle before the report
    property p_rei_spe; rei_o.valid && $past(per_spe_r) |-> rei_o.count <= 4'h1; endproperty
    a_rei_spe: assert property (p_rei_spe) else $error("per-spe nibble above 1");
    property p_err_irq; rei_o.valid && rei_o.count != 4'h0 |-> !irq_n_o; endproperty
    a_err_irq: assert property (p_err_irq) else $error("parity error without irq");
    property p_irq_hold; !irq_n_o && !reg_rd_i |=> !irq_n_o; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without read");
    property p_rem_irq;
        ce_i && g1_ev && spe_i.data[7:4] != 4'h0 && spe_i.data[7:4] <= 4'h8 |=> !irq_n_o;
    endproperty
    a_rem_irq: assert property (p_rem_irq) else $error("remote error without irq");
    property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    // second back-to-back read must see the cleared byte when nothing arrived
    property p_rc_twice;
        rd_rem && !g1_ev && !$past(g1_ev) ##1 rd_rem |=> reg_rdata_o == 8'h00;
    endproperty
    a_rc_twice: assert property (p_rc_twice) else $error("byte not cleared by read");
    c_par: cover property (rei_o.valid && rei_o.count != 4'h0);
    c_rem: cover property (g1_ev && spe_i.data[7:4] != 4'h0);
    c_rc: cover property (rd_rem ##1 rd_rem);
endmodule
bind pem_path_error_monitor pem_asserts #(.CHANNEL_ID(CHANNEL_ID)) pem_asserts_i (
    .sys_clk_i, .rst_i, .ce_i, .spe_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rei_o, .irq_n_o);

//--- pem_spe_src.sv
`timescale 1ns/1ps
module pem_spe_src (
    input wire logic             clk_i,  // bench clock
    output pem_pkg::pem_spe_type spe_o   // byte stream into the monitor
);
    pem_pkg::pem_spe_type q[$];         // bytes waiting to go out
    logic [7:0]           bip_r = 8'h00;  // parity of the last spe queued
    initial spe_o = '0;
    // one byte a cycle; idle cycles carry junk so stale values never look valid
    always @(posedge clk_i) begin
        if (q.size() != 0) spe_o <= q.pop_front();
        else spe_o <= {1'b0, 11'($urandom)};
    end
    task automatic send_spe(input logic [7:0] err, input logic [3:0] nib, input int len);
        logic [7:0] acc;
        logic [7:0] d;
        acc = 8'($urandom);
        q.push_back({4'b1100, acc});
        d = bip_r ^ err;  // parity of the previous spe, spoiled on request
        acc ^= d;
        q.push_back({4'b1010, d});
        d = {nib, 4'($urandom)};
        acc ^= d;
        q.push_back({4'b1001, d});
        repeat (len) begin
            if ($urandom % 4 == 0) q.push_back({1'b0, 11'($urandom)});  // gap
            d = 8'($urandom);
            acc ^= d;
            q.push_back({4'b1000, d});
        end
        bip_r = acc;
        while (q.size() != 0) @(posedge clk_i);
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                 sys_clk_i   = 1'b0;
    logic                 rst_i       = 1'b1;
    logic                 ce_i        = 1'b1;  // low for one write to prove the freeze
    pem_pkg::pem_spe_type spe;
    logic [15:0]          reg_addr_i  = 16'h0000;
    logic [7:0]           reg_wdata_i = 8'h00;
    logic                 reg_wr_i    = 1'b0;
    logic                 reg_rd_i    = 1'b0;
    logic [7:0]           reg_rdata_o;
    pem_pkg::pem_rei_type rei_o;
    logic                 irq_n_o;
    int                   num_errors = 0;
    int                   compares   = 0;
    int                   cycles     = 0;
    logic [7:0]           rd_q[$];   // expected read bytes
    logic [3:0]           rei_q[$];  // expected returned nibbles
    logic                 rd_seen = 1'b0;
    logic [7:0]           err;
    logic [3:0]           nib, n;
    logic [31:0]          par, rem;  // expected tallies
    logic                 pe, re, first = 1'b1;
    int                   m, k, b;
    always #20 sys_clk_i = ~sys_clk_i;
    pem_path_error_monitor #(.CHANNEL_ID(1)) pem_path_error_monitor_i (
        .sys_clk_i, .rst_i, .ce_i, .spe_i(spe), .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rei_o, .irq_n_o);
    pem_spe_src pem_spe_src_i (.clk_i(sys_clk_i), .spe_o(spe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle; for reads d is the expected answer
    task automatic bus(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
        {reg_wr_i, reg_rd_i} <= op;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (op[0]) rd_q.push_back(d);
        @(posedge sys_clk_i);
    endtask
    task automatic idle_chk_irq(input logic exp);
        {reg_wr_i, reg_rd_i} <= 2'b00;
        @(negedge sys_clk_i);
        chk({7'h00, irq_n_o}, {7'h00, exp});
        @(posedge sys_clk_i);
    endtask
    task automatic complete_run();
        // a promised result that never showed up is a mismatch too
        if (rd_q.size() != 0 || rei_q.size() != 0) begin
            num_errors++;
            $display("wrong value at %0t: expected results never seen", $time);
        end
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // results are taken mid-cycle, well clear of the launching edge
    always @(negedge sys_clk_i) begin
        if (rd_seen) chk(reg_rdata_o, rd_q.pop_front());
        // a report with nothing queued cannot match the impossible 8'hFF
        if (rei_o.valid === 1'b1) begin
            if (rei_q.size() == 0) chk({4'h0, rei_o.count}, 8'hFF);
            else chk({4'h0, rei_o.count}, {4'h0, rei_q.pop_front()});
        end
        rd_seen = reg_rd_i;
    end
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(27306));
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        bus(2'b01, 16'h1183, 8'h01);
        bus(2'b01, 16'h2183, 8'h00);  // other channel stays silent
        bus(2'b01, 16'h1100, 8'h00);  // unmapped offset
        bus(2'b10, 16'h1183, 8'hFF);
        bus(2'b01, 16'h1183, 8'h0F);  // upper nibble reads zero
        idle_chk_irq(1'b1);  // lets read data return to zero first
        // a write while the enable is low must not land
        ce_i <= 1'b0;
        bus(2'b10, 16'h1183, 8'h00);
        ce_i <= 1'b1;
        bus(2'b01, 16'h1183, 8'h0F);  // control byte unchanged
        for (m = 0; m < 4; m++) begin
            bus(2'b10, 16'h1183, 8'(m));
            idle_chk_irq(1'b1);
            par = 0;
            rem = 0;
            pe = 0;
            re = 0;
            for (k = 0; k < 6; k++) begin
                err = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
                nib = 4'($urandom);
                n = (nib > 4'h8) ? 4'h0 : nib;  // out-of-range nibbles carry no errors
                if (!first) begin  // first spe ever has no reference
                    rei_q.push_back(m[0] ? 4'(err != 0) : 4'($countones(err)));
                    par += m[0] ? 32'(err != 0) : 32'($countones(err));
                    pe |= (err != 0);
                end
                rem += m[1] ? 32'(n != 0) : 32'(n);
                re |= (n != 0);
                first = 0;
                pem_spe_src_i.send_spe(err, nib, $urandom % 5);
            end
            repeat (3) @(posedge sys_clk_i);
            idle_chk_irq(!(pe || re));
            for (b = 0; b < 4; b++) bus(2'b01, 16'h1198 + 16'(b), par[31-8*b -: 8]);
            for (b = 0; b < 4; b++) bus(2'b01, 16'h119C + 16'(b), rem[31-8*b -: 8]);
            bus(2'b01, 16'h119F, 8'h00);
            bus(2'b01, 16'h118A, {1'b0, re, 6'h00});
            bus(2'b01, 16'h118B, {pe, 7'h00});
            bus(2'b01, 16'h118B, 8'h00);
            idle_chk_irq(1'b1);
        end
        complete_run();
    end
endmodule
